//--- verilog/diag_readback.sv
// diagnostic word, readback selection and serial write lockout
// assumes a three-wire serial port; words are stable while latch enable is high
`timescale 1ns/10ps
`default_nettype none
// How it works
// - twenty-bit read-only diagnostic status word
// - core index encoded 0,1,2,4 for cores
// - feedback pin activity flag is sticky
// - register 5 bit 30 clears feedback flag
// - reference pin activity flag is sticky
// - calibration active bit shows running calibration
// - upper calibration failure bit reported
// - lower calibration failure bit reported
// - tuning voltage over limit bit reported
// - tuning voltage in range bit reported
// - fastlock asserted when its pin low
// - phase lock flag is digital lock only
// - lock, enable and buffer pin levels shown
// - readback select picks register zero to fifteen
// - id select returns part identification
// - lockout ignores writes except lockout change
// - readback drives status pin when source four
module diag_readback
    import diag_readback_pkg::*;
#(
    parameter logic [31:0] PART_ID = PART_ID_DEF
)
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_ser_clk,
    input  wire logic              i_ser_data,
    input  wire logic              i_ser_le,
    input  wire logic              i_fb_pin,
    input  wire logic              i_ref_pin,
    input  wire logic [CORE_W-1:0] i_core_num,
    input  wire logic              i_cal_running,
    input  wire logic              i_cal_fail_upper,
    input  wire logic              i_cal_fail_lower,
    input  wire logic              i_tune_over,
    input  wire logic              i_tune_ok,
    input  wire logic              i_fastlock_pin,
    input  wire logic              i_phase_lock,
    input  wire logic              i_lock_pin,
    input  wire logic              i_chip_enable,
    input  wire logic              i_buffer_enable,
    output logic                   o_mux_pin,
    output logic      [DIAG_W-1:0] o_diag,
    output logic                   o_write_lockout
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [2:0] core_code(input logic [CORE_W-1:0] num);
        logic [2:0] c;
        c = CORE1_CODE;
        case (num)
            2'h1:    c = CORE2_CODE;
            2'h2:    c = CORE3_CODE;
            2'h3:    c = CORE4_CODE;
            default: c = CORE1_CODE;
        endcase
        return c;
    endfunction : core_code

    function automatic logic [DIAG_W-1:0] build_diag(input logic [2:0]      code,
                                                     input logic            fb,
                                                     input logic            rf,
                                                     input logic [ST_W-1:0] st);
        logic [DIAG_W-1:0] w;
        w = '0;
        w[DG_CORE_LSB +: 2] = code[1:0];
        w[DG_CORE_HI]       = code[2];
        w[DG_FB_ACT]        = fb;
        w[DG_REF_ACT]       = rf;
        w[DG_CAL_RUN]       = st[ST_CAL_RUN];
        w[DG_FAIL_UP]       = st[ST_FAIL_UP];
        w[DG_FAIL_LO]       = st[ST_FAIL_LO];
        w[DG_TUNE_OVER]     = st[ST_TUNE_OVER];
        w[DG_TUNE_OK]       = st[ST_TUNE_OK];
        w[DG_FL_ON]         = ~st[ST_FL_PIN];
        w[DG_PLOCK]         = st[ST_PLOCK];
        w[DG_LOCK_PIN]      = st[ST_LOCK_PIN];
        w[DG_CE]            = st[ST_CE];
        w[DG_BUFEN]         = st[ST_BUFEN];
        return w;
    endfunction : build_diag

    function automatic logic pin_source(input logic [4:0]        src,
                                        input logic [DIAG_W-1:0] dg,
                                        input logic              rb);
        logic v;
        v = 1'b0;
        case (src)
            SRC_VCC:      v = 1'b1;
            SRC_LOCK:     v = dg[DG_PLOCK];
            SRC_READBACK: v = rb;
            SRC_REF_ACT:  v = dg[DG_REF_ACT];
            SRC_FB_ACT:   v = dg[DG_FB_ACT];
            SRC_CAL_RUN:  v = dg[DG_CAL_RUN];
            SRC_TUNE_BAD: v = ~dg[DG_TUNE_OK];
            SRC_FAIL_LO:  v = dg[DG_FAIL_LO];
            SRC_FAIL_UP:  v = dg[DG_FAIL_UP];
            default:      v = 1'b0;
        endcase
        return v;
    endfunction : pin_source

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock domain: shift in the write word, shift out readback

    typedef struct packed {
        logic [REG_W-1:0] sh;
        logic [REG_W-1:0] rb_sh;
        logic             rb_out;
    } ser_s;

    ser_s             s_q;
    ser_s             s_d;
    logic             first_q;
    logic [REG_W-1:0] rb_word_q;

    // latch enable marks the frame boundary; the serial clock stops between frames
    always_ff @(posedge i_ser_clk or posedge i_ser_le)
    begin
        if (i_ser_le)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    always_comb
    begin
        s_d    = s_q;
        s_d.sh = {s_q.sh[REG_W-2:0], i_ser_data};
        if (first_q)
        begin
            // rb_word_q is frozen by the reference side while the frame runs
            s_d.rb_out = rb_word_q[REG_W-1];
            s_d.rb_sh  = {rb_word_q[REG_W-2:0], 1'b0};
        end
        else
        begin
            s_d.rb_out = s_q.rb_sh[REG_W-1];
            s_d.rb_sh  = {s_q.rb_sh[REG_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_ser_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference clock domain

    typedef struct packed {
        logic              le_m;
        logic              le_s;
        logic              le_d;
        logic              fb_m;
        logic              fb_s;
        logic              fb_p;
        logic              rf_m;
        logic              rf_s;
        logic              rf_p;
        logic [ST_W-1:0]   st_m;
        logic [ST_W-1:0]   st_s;
        logic [CORE_W-1:0] core_m;
        logic [CORE_W-1:0] core_s;
        logic              rb_m;
        logic              rb_s;
        logic              fb_act;
        logic              rf_act;
        logic              clr_fb;
        logic              clr_rf;
        logic              lockout;
        logic [3:0]        rdsel;
        logic              idsel;
        logic [4:0]        mux_src;
        logic [REG_W-1:0]  rb_word;
        logic [DIAG_W-1:0] diag;
        logic              mux_out;
        logic              wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [REG_W-1:0]  wr_data;
    } ref_s;

    ref_s             q;
    ref_s             d;
    logic [REG_W-1:0] mem_rd;
    logic             le_rise;
    logic [3:0]       w_addr;
    logic             w_ok;
    logic             fb_edge;
    logic             rf_edge;

    always_comb
    begin
        d = q;
        // two-flop synchronisers; the first stage feeds only the second, a third flop feeds the edge detectors
        d.le_m   = i_ser_le;
        d.le_s   = q.le_m;
        d.le_d   = q.le_s;
        d.fb_m   = i_fb_pin;
        d.fb_s   = q.fb_m;
        d.fb_p   = q.fb_s;
        d.rf_m   = i_ref_pin;
        d.rf_s   = q.rf_m;
        d.rf_p   = q.rf_s;
        d.st_m   = {i_buffer_enable, i_chip_enable, i_lock_pin, i_phase_lock,
                    i_fastlock_pin, i_tune_ok, i_tune_over, i_cal_fail_lower,
                    i_cal_fail_upper, i_cal_running};
        d.st_s   = q.st_m;
        d.core_m = i_core_num;
        d.core_s = q.core_m;
        d.rb_m   = s_q.rb_out;
        d.rb_s   = q.rb_m;

        le_rise = q.le_s & ~q.le_d;
        w_addr  = s_q.sh[ADDR_W-1:0];
        // under lockout only a write that drops the lockout bit gets through
        w_ok    = ~q.lockout | ((w_addr == REG6_IDX) & ~s_q.sh[LOCK_BIT]);

        // the sticky flags: an edge in the clearing cycle still sets the flag
        fb_edge  = q.fb_s ^ q.fb_p;
        rf_edge  = q.rf_s ^ q.rf_p;
        d.fb_act = fb_edge | (q.fb_act & ~q.clr_fb);
        d.rf_act = rf_edge | (q.rf_act & ~q.clr_rf);

        d.wr_en   = 1'b0;
        d.wr_addr = w_addr;
        d.wr_data = s_q.sh;
        if (le_rise && w_ok)
        begin
            d.wr_en = 1'b1;
            if (w_addr == REG5_IDX)
            begin
                d.clr_fb = s_q.sh[CLR_FB_BIT];
                d.clr_rf = s_q.sh[CLR_REF_BIT];
                if (s_q.sh[REG_RST_BIT])
                begin
                    d.lockout = 1'b0;
                    d.rdsel   = RDSEL_RST;
                    d.idsel   = 1'b0;
                    d.mux_src = MUXSRC_RST;
                end
            end
            else if (w_addr == REG6_IDX)
            begin
                d.lockout = s_q.sh[LOCK_BIT];
                d.rdsel   = s_q.sh[RDSEL_LSB +: RDSEL_W];
                d.idsel   = s_q.sh[IDSEL_BIT];
            end
            else if (w_addr == REG7_IDX)
            begin
                d.mux_src = s_q.sh[MUXSRC_LSB +: MUXSRC_W];
            end
        end

        d.diag = build_diag(core_code(q.core_s), q.fb_act, q.rf_act, q.st_s);

        // hold the readback word still while a frame is in flight
        if (q.le_s && q.le_d)
        begin
            if (q.idsel)
                d.rb_word = PART_ID;
            else if (q.rdsel == REG6_IDX)
                d.rb_word = {1'b0, q.diag, q.idsel, 1'b0, q.rdsel, q.lockout, REG6_IDX};
            else
                d.rb_word = mem_rd;
        end

        d.mux_out = pin_source(q.mux_src, q.diag, q.rb_s);
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q         <= '0;
            q.le_m    <= 1'b1;
            q.le_s    <= 1'b1;
            q.le_d    <= 1'b1;
            q.rdsel   <= RDSEL_RST;
            q.mux_src <= MUXSRC_RST;
        end
        else
        begin
            q <= d;
        end
    end

    reg_store u_store (
        .i_ref_clk (i_ref_clk),
        .i_wr_en   (q.wr_en),
        .i_wr_addr (q.wr_addr),
        .i_wr_data (q.wr_data),
        .i_rd_addr (q.rdsel),
        .o_rd_data (mem_rd)
    );

    assign rb_word_q       = q.rb_word;
    assign o_mux_pin       = q.mux_out;
    assign o_diag          = q.diag;
    assign o_write_lockout = q.lockout;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    fb_sticky_set_a: assert property ((q.fb_s != q.fb_p) |=> q.fb_act ##1 o_diag[DG_FB_ACT])
        else $error("feedback activity not flagged");
    rf_sticky_set_a: assert property ((q.rf_s != q.rf_p) |=> q.rf_act ##1 o_diag[DG_REF_ACT])
        else $error("reference activity not flagged");
    flag_hold_a: assert property (q.fb_act && !q.clr_fb && !fb_edge |=> q.fb_act)
        else $error("feedback flag dropped without a clear");
    fb_clear_a: assert property (q.clr_fb && !fb_edge |=> !q.fb_act)
        else $error("feedback flag not cleared");
    rf_clear_a: assert property (q.clr_rf && !rf_edge |=> !q.rf_act)
        else $error("reference flag not cleared");
    lockout_block_a: assert property (le_rise && q.lockout && w_addr != REG6_IDX |=> !q.wr_en)
        else $error("write taken under lockout");
    part_id_a: assert property (q.le_s && q.le_d && q.idsel |=> q.rb_word == PART_ID)
        else $error("part identification not selected");
    phase_lock_a: assert property (q.st_s[ST_PLOCK] |=> o_diag[DG_PLOCK])
        else $error("phase lock bit not reported");
    // case equality: an unwritten register reads back unknown and must still pass through
    readback_pin_a: assert property (q.mux_src == SRC_READBACK |=> o_mux_pin === $past(q.rb_s))
        else $error("readback bit not on status pin");

endmodule : diag_readback
`default_nettype wire

//--- verilog/diag_readback_pkg.sv
// constants for the diagnostic readback and write lockout block
// assumes a 32-bit serial word whose low nibble is the register number
package diag_readback_pkg;

    localparam int          REG_W        = 32;
    localparam int          ADDR_W       = 4;
    localparam int          DIAG_W       = 20;
    localparam int          ST_W         = 10;
    localparam int          CORE_W       = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // register numbers carried in word[3:0]
    localparam logic [3:0]  REG5_IDX     = 4'h5;
    localparam logic [3:0]  REG6_IDX     = 4'h6;
    localparam logic [3:0]  REG7_IDX     = 4'h7;

    // register 5 fields
    localparam int          CLR_FB_BIT   = 30;
    localparam int          CLR_REF_BIT  = 29;
    localparam int          REG_RST_BIT  = 4;
    // register 6 fields
    localparam int          LOCK_BIT     = 4;
    localparam int          RDSEL_LSB    = 5;
    localparam int          RDSEL_W      = 4;
    localparam int          IDSEL_BIT    = 10;
    localparam int          DIAG_LSB     = 11;
    // register 7 field
    localparam int          MUXSRC_LSB   = 4;
    localparam int          MUXSRC_W     = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0]  RDSEL_RST    = 4'hf;
    localparam logic [4:0]  MUXSRC_RST   = 5'h04;

    // status pin source codes
    localparam logic [4:0]  SRC_VCC      = 5'h00;
    localparam logic [4:0]  SRC_LOCK     = 5'h01;
    localparam logic [4:0]  SRC_READBACK = 5'h04;
    localparam logic [4:0]  SRC_REF_ACT  = 5'h0a;
    localparam logic [4:0]  SRC_FB_ACT   = 5'h0b;
    localparam logic [4:0]  SRC_CAL_RUN  = 5'h0c;
    localparam logic [4:0]  SRC_TUNE_BAD = 5'h0d;
    localparam logic [4:0]  SRC_FAIL_LO  = 5'h0e;
    localparam logic [4:0]  SRC_FAIL_UP  = 5'h0f;

    ////////////////////////////////////////////////////////////////////////////////
    // status input vector positions
    localparam int          ST_CAL_RUN   = 0;
    localparam int          ST_FAIL_UP   = 1;
    localparam int          ST_FAIL_LO   = 2;
    localparam int          ST_TUNE_OVER = 3;
    localparam int          ST_TUNE_OK   = 4;
    localparam int          ST_FL_PIN    = 5;
    localparam int          ST_PLOCK     = 6;
    localparam int          ST_LOCK_PIN  = 7;
    localparam int          ST_CE        = 8;
    localparam int          ST_BUFEN     = 9;

    // diagnostic word positions
    localparam int          DG_CORE_LSB  = 18;
    localparam int          DG_FB_ACT    = 17;
    localparam int          DG_REF_ACT   = 16;
    localparam int          DG_CORE_HI   = 15;
    localparam int          DG_CAL_RUN   = 10;
    localparam int          DG_FAIL_UP   = 9;
    localparam int          DG_FAIL_LO   = 8;
    localparam int          DG_TUNE_OVER = 6;
    localparam int          DG_TUNE_OK   = 5;
    localparam int          DG_FL_ON     = 4;
    localparam int          DG_PLOCK     = 3;
    localparam int          DG_LOCK_PIN  = 2;
    localparam int          DG_CE        = 1;
    localparam int          DG_BUFEN     = 0;

    // core codes for cores 1..4
    localparam logic [2:0]  CORE1_CODE   = 3'h0;
    localparam logic [2:0]  CORE2_CODE   = 3'h1;
    localparam logic [2:0]  CORE3_CODE   = 3'h2;
    localparam logic [2:0]  CORE4_CODE   = 3'h4;

    // arbitrary identification value
    localparam logic [31:0] PART_ID_DEF  = 32'h0000_5a3c;

endpackage : diag_readback_pkg

//--- verilog/reg_store.sv
// sixteen-word register image written by accepted serial words
// assumes writes and reads on the reference clock; read data is registered
`timescale 1ns/10ps
`default_nettype none
module reg_store
    import diag_readback_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_wr_en,
    input  wire logic [ADDR_W-1:0] i_wr_addr,
    input  wire logic [REG_W-1:0]  i_wr_data,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [REG_W-1:0]  o_rd_data
);

    typedef struct packed {
        logic [15:0][REG_W-1:0] mem;
        logic [REG_W-1:0]       rd;
    } store_s;

    store_s q;
    store_s d;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        if (i_wr_en)
        begin
            d.mem[i_wr_addr] = i_wr_data;
        end
        d.rd = q.mem[i_rd_addr];
    end

    // no reset: contents are undefined until the host writes them
    always_ff @(posedge i_ref_clk)
    begin
        q <= d;
    end

    assign o_rd_data = q.rd;

endmodule : reg_store
`default_nettype wire

//--- verilog/_unused_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- testbench/host_ser.sv
// host model driving the three-wire serial port of the diagnostic block
// assumes the bench calls its tasks one at a time; clock stands still between frames
`timescale 1ns/10ps
`default_nettype none
module host_ser
    import diag_readback_pkg::*;
(
    output logic      o_ser_clk,
    output logic      o_ser_data,
    output logic      o_ser_le,
    input  wire logic i_mux_pin
);
    initial
    begin
        o_ser_clk  = 1'b0;
        o_ser_data = 1'b0;
        o_ser_le   = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one 32-bit frame, msb first; status pin sampled mid-period gives the readback word
    task automatic xfer(input logic [31:0] w, output logic [31:0] rb);
        o_ser_le = 1'b0;
        // 42 + 198 keeps every frame at the same phase, clear of reference edges
        #42;
        for (int i = 31; i >= 0; i--)
        begin
            o_ser_data = w[i];
            #40;
            o_ser_clk = 1'b1;
            #40;
            o_ser_clk = 1'b0;
            rb[i] = i_mux_pin;
        end
        o_ser_le = 1'b1;
        // released data line shows the inverse so a stale level cannot pass for data
        o_ser_data = ~o_ser_data;
        // le stays high well beyond the 6 ref clocks the commit needs
        #198;
    endtask : xfer

    // set-then-clear sequence on one register 5 clear bit
    task automatic clear_flag(input int b);
        logic [31:0] rb;
        xfer((32'h1 << b) | {28'h0, REG5_IDX}, rb);
        xfer({28'h0, REG5_IDX}, rb);
    endtask : clear_flag
endmodule : host_ser
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the diagnostic readback and write lockout block
// assumes the host model owns the serial port; status inputs are driven here
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import diag_readback_pkg::*;
;
    localparam logic [31:0] ID_VAL = 32'h1234_abcd; // arbitrary identification value
    localparam logic [31:0] W15    = 32'hc0de_a51f;

    logic              i_ref_clk;
    logic              i_nrst;
    logic              fb_pin;
    logic              ref_pin;
    logic [ST_W-1:0]   st;
    logic [CORE_W-1:0] core;
    logic              fbf;
    logic              rff;
    logic [31:0]       rb;
    wire               ser_clk;
    wire               ser_data;
    wire               ser_le;
    logic              mux_pin;
    logic              lockout;
    logic [DIAG_W-1:0] diag;
    int                error_cnt;
    int                comparisons;

    initial
    begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    diag_readback #(.PART_ID(ID_VAL)) u_dut (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ser_clk(ser_clk),
        .i_ser_data(ser_data), .i_ser_le(ser_le), .i_fb_pin(fb_pin), .i_ref_pin(ref_pin),
        .i_core_num(core), .i_cal_running(st[ST_CAL_RUN]),
        .i_cal_fail_upper(st[ST_FAIL_UP]), .i_cal_fail_lower(st[ST_FAIL_LO]),
        .i_tune_over(st[ST_TUNE_OVER]), .i_tune_ok(st[ST_TUNE_OK]),
        .i_fastlock_pin(st[ST_FL_PIN]), .i_phase_lock(st[ST_PLOCK]),
        .i_lock_pin(st[ST_LOCK_PIN]), .i_chip_enable(st[ST_CE]),
        .i_buffer_enable(st[ST_BUFEN]), .o_mux_pin(mux_pin), .o_diag(diag),
        .o_write_lockout(lockout));

    host_ser u_host (.o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_ser_le(ser_le),
                     .i_mux_pin(mux_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic end_sim;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    function automatic logic [DIAG_W-1:0] exp_diag();
        logic [2:0]        k;
        logic [DIAG_W-1:0] d;
        k = (core == 2'h3) ? CORE4_CODE : {1'b0, core};
        d = '0;
        d[DG_CORE_LSB +: 2] = k[1:0];
        d[DG_CORE_HI]       = k[2];
        d[DG_FB_ACT]        = fbf;
        d[DG_REF_ACT]       = rff;
        d[DG_CAL_RUN]       = st[ST_CAL_RUN];
        d[DG_FAIL_UP]       = st[ST_FAIL_UP];
        d[DG_FAIL_LO]       = st[ST_FAIL_LO];
        d[DG_TUNE_OVER]     = st[ST_TUNE_OVER];
        d[DG_TUNE_OK]       = st[ST_TUNE_OK];
        d[DG_FL_ON]         = ~st[ST_FL_PIN];
        d[DG_PLOCK]         = st[ST_PLOCK];
        d[DG_LOCK_PIN]      = st[ST_LOCK_PIN];
        d[DG_CE]            = st[ST_CE];
        d[DG_BUFEN]         = st[ST_BUFEN];
        return d;
    endfunction : exp_diag

    // synchroniser plus register needs up to 4 clocks; 6 leaves margin
    task automatic chk_diag;
        tick(6);
        chk_word({12'h0, diag}, {12'h0, exp_diag()});
    endtask : chk_diag

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        chk_bit(lockout, 1'b0);
        u_host.xfer({28'h0, REG5_IDX}, rb);
        u_host.xfer(W15, rb);
        u_host.xfer(W15, rb);
        chk_word(rb, W15);
        $display("t_defaults done");
    endtask : t_defaults

    task automatic t_diag;
        for (int b = 0; b < ST_W; b++)
        begin
            tick(1);
            st = 10'h020 ^ (10'h001 << b);
            chk_diag();
        end
        for (int c = 0; c < 4; c++)
        begin
            tick(1);
            core = c[1:0];
            chk_diag();
        end
        $display("t_diag done");
    endtask : t_diag

    task automatic t_flags;
        tick(1);
        fb_pin  = 1'b1;
        ref_pin = 1'b1;
        tick(2);
        fb_pin  = 1'b0;
        ref_pin = 1'b0;
        fbf     = 1'b1;
        rff     = 1'b1;
        tick(20);
        chk_diag();
        u_host.xfer(W15, rb);
        chk_diag();
        u_host.clear_flag(CLR_FB_BIT);
        fbf = 1'b0;
        chk_diag();
        u_host.clear_flag(CLR_REF_BIT);
        rff = 1'b0;
        chk_diag();
        $display("t_flags done");
    endtask : t_flags

    task automatic t_readsel;
        logic [31:0] w6;
        w6 = (32'h6 << RDSEL_LSB) | {28'h0, REG6_IDX};
        u_host.xfer((32'h1 << IDSEL_BIT) | (32'hf << RDSEL_LSB) | {28'h0, REG6_IDX}, rb);
        u_host.xfer(w6, rb);
        chk_word(rb, ID_VAL);
        u_host.xfer(w6, rb);
        chk_word(rb, {1'b0, exp_diag(), 2'b00, 4'h6, 1'b0, 4'h6});
        // soft reset through register 5 must bring back select 15 and drop id select
        u_host.xfer((32'h1 << IDSEL_BIT) | {28'h0, REG6_IDX}, rb);
        u_host.xfer((32'h1 << REG_RST_BIT) | {28'h0, REG5_IDX}, rb);
        u_host.xfer(W15, rb);
        chk_word(rb, W15);
        $display("t_readsel done");
    endtask : t_readsel

    task automatic t_lock;
        logic [31:0] w_unl;
        w_unl = (32'hf << RDSEL_LSB) | {28'h0, REG6_IDX};
        u_host.xfer(w_unl | (32'h1 << LOCK_BIT), rb);
        chk_bit(lockout, 1'b1);
        // both writes must be dropped while locked
        u_host.xfer(32'h5555_555f, rb);
        u_host.xfer({23'h0, SRC_VCC, REG7_IDX}, rb);
        u_host.xfer(w_unl, rb);
        chk_bit(lockout, 1'b0);
        u_host.xfer(W15, rb);
        chk_word(rb, W15);
        u_host.xfer({23'h0, SRC_VCC, REG7_IDX}, rb);
        chk_bit(mux_pin, 1'b1);
        u_host.xfer({23'h0, SRC_LOCK, REG7_IDX}, rb);
        chk_bit(mux_pin, st[ST_PLOCK]);
        u_host.xfer({23'h0, SRC_TUNE_BAD, REG7_IDX}, rb);
        chk_bit(mux_pin, ~st[ST_TUNE_OK]);
        u_host.xfer({23'h0, SRC_READBACK, REG7_IDX}, rb);
        $display("t_lock done");
    endtask : t_lock

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        i_nrst      = 1'b0;
        fb_pin      = 1'b0;
        ref_pin     = 1'b0;
        st          = 10'h020;
        core        = 2'h0;
        fbf         = 1'b0;
        rff         = 1'b0;
        error_cnt   = 0;
        comparisons = 0;
        repeat (8) @(posedge i_ref_clk);
        #1;
        i_nrst = 1'b1;
        tick(4);
        t_defaults();
        t_diag();
        t_flags();
        t_readsel();
        t_lock();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
